// File: core/ser_status_bank.sv
/*
  status and event reporting bank: one register set per interface instance,
  status byte, service request, parallel poll status and poll line drive.
  assumes a command decoder that issues one operation per cycle, an event
  source that tags each event with its instance, and a bus transceiver that
  resolves the poll lines from dio_oe with pull-ups.
*/
`default_nettype none
module ser_status_bank #(
  parameter int unsigned VERIFY_CYCLES = ser_pkg::VERIFY_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register operations from the command decoder
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_inst,
  input wire ser_pkg::ser_op_e cmd_op,
  input wire logic [1:0] cmd_idx,
  input wire logic [7:0] cmd_data,
  // query answers
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // output limit event pulses, shared by all instances
  input wire logic [ser_pkg::NUM_OUT-1:0][7:0] lim_evt,
  // instance-tagged events from parser, formatter and queues
  input wire logic [2:0] evt_inst,
  input wire logic evt_cmd_error,
  input wire logic evt_exec_wr,
  input wire logic [7:0] evt_exec_code,
  input wire logic evt_access_denied,
  input wire logic evt_verify_start,
  input wire logic evt_verify_reached,
  input wire logic evt_talk_addressed,
  input wire logic evt_formatter_idle,
  input wire logic evt_queue_empty,
  input wire logic evt_queue_full,
  input wire logic evt_terminator,
  input wire logic evt_multi_end,
  input wire logic evt_rsp_ready,
  input wire logic evt_rsp_done,
  // parser and formatter control per instance
  output logic [ser_pkg::NUM_INST-1:0] parser_reset,
  output logic [ser_pkg::NUM_INST-1:0] discard_rsp,
  // service request and parallel poll of the bus instance
  output logic srq,
  output logic ist,
  input wire logic pp_active,
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe
);
  import ser_pkg::*;

  typedef struct packed {
    ser_inst_s [NUM_INST-1:0] inst;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [NUM_INST-1:0] parser_reset;
    logic [NUM_INST-1:0] discard;
    logic srq;
    logic ist;
    logic pp_cfg;
    logic [2:0] pp_line;
    logic pp_sense;
    logic [7:0] dio_out;
    logic [7:0] dio_oe;
  } ser_top_s;

  ser_top_s st;
  ser_top_s next_st;
  logic [NUM_INST-1:0] vfy_to;
  logic [NUM_INST-1:0][7:0] esr_set;
  logic [7:0] stb0;
  logic ist0;

  // one verify timer per instance
  for (genvar g = 0; g < NUM_INST; g++) begin : g_vfy
    ser_verify_timer #(
      .CYCLES(VERIFY_CYCLES)
    ) u_vfy (
      .clk(clk),
      .rst(rst),
      .start(evt_verify_start && evt_inst == 3'(g)),
      .reached(evt_verify_reached && evt_inst == 3'(g)),
      .timeout(vfy_to[g])
    );
  end

  // register update of every instance, then answer and poll drive
  always_comb begin
    logic hit;
    logic ev;
    logic clr;
    logic unterm;
    logic dead;
    logic intr;
    logic exec_set;
    logic mss;
    logic [7:0] set;
    ser_inst_s sel;
    logic [7:0] sel_stb;
    hit = 1'b0;
    ev = 1'b0;
    clr = 1'b0;
    unterm = 1'b0;
    dead = 1'b0;
    intr = 1'b0;
    exec_set = 1'b0;
    mss = 1'b0;
    set = 8'h00;
    sel = '0;
    sel_stb = 8'h00;
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_data = 8'h00;
    next_st.parser_reset = '0;
    next_st.discard = '0;
    next_st.dio_out = 8'h00;
    esr_set = '0;
    for (int i = 0; i < NUM_INST; i++) begin
      // each instance sees only its own operations and tagged events; limit events reach every instance
      hit = cmd_valid && cmd_inst == 3'(i);
      ev = evt_inst == 3'(i);
      clr = hit && cmd_op == OP_CLEAR;
      // limit events latch, read clears, the event wins over the clear
      for (int o = 0; o < NUM_OUT; o++) begin
        if ((hit && cmd_op == OP_RD_LIM_EVT && cmd_idx == 2'(o)) || clr) begin
          next_st.inst[i].lsr[o] = 8'h00;
        end
        next_st.inst[i].lsr[o] = next_st.inst[i].lsr[o] | (lim_evt[o] & LIM_VALID_MASK);
        if (hit && cmd_op == OP_WR_LIM_MASK && cmd_idx == 2'(o)) begin
          next_st.inst[i].lse[o] = cmd_data;
        end
      end
      // query error conditions
      unterm = ev && evt_talk_addressed && evt_formatter_idle && evt_queue_empty;
      dead = ev && evt_queue_full && st.inst[i].mav;
      intr = ev && (evt_terminator || evt_multi_end) && st.inst[i].mav;
      exec_set = ev && ((evt_exec_wr && evt_exec_code != EER_NONE) || evt_access_denied);
      // standard event sources; bits 6 and 1 never set
      set = 8'h00;
      set[ESR_CMD_ERR] = ev && evt_cmd_error;
      set[ESR_EXEC_ERR] = exec_set;
      set[ESR_VERIFY] = vfy_to[i];
      set[ESR_QUERY_ERR] = unterm || dead || intr;
      set[ESR_OP_DONE] = hit && cmd_op == OP_OPC;
      esr_set[i] = set;
      if ((hit && cmd_op == OP_RD_ESR) || clr) begin
        next_st.inst[i].standard_event_status = 8'h00;
      end
      next_st.inst[i].standard_event_status = next_st.inst[i].standard_event_status | set;
      // execution error code, cleared on read, newest code kept
      if ((hit && cmd_op == OP_RD_EER) || clr) begin
        next_st.inst[i].execution_error_code = EER_NONE;
      end
      if (ev && evt_exec_wr) begin
        next_st.inst[i].execution_error_code = evt_exec_code;
      end
      if (ev && evt_access_denied) begin
        next_st.inst[i].execution_error_code = EER_ACCESS_DENIED;
      end
      // query error code, most severe condition wins
      if ((hit && cmd_op == OP_RD_QER) || clr) begin
        next_st.inst[i].query_error_code = 8'h00;
      end
      if (intr) begin
        next_st.inst[i].query_error_code = QER_INTERRUPTED;
      end
      if (dead) begin
        next_st.inst[i].query_error_code = QER_DEADLOCK;
      end
      if (unterm) begin
        next_st.inst[i].query_error_code = QER_UNTERMINATED;
      end
      // enable registers
      if (hit && cmd_op == OP_WR_ESE) begin
        next_st.inst[i].standard_event_mask = cmd_data;
      end
      if (hit && cmd_op == OP_WR_SRE) begin
        next_st.inst[i].service_request_mask = cmd_data;
      end
      if (hit && cmd_op == OP_WR_PRE) begin
        next_st.inst[i].pre = cmd_data;
      end
      // message available: ready sets, terminator sent or discard clears
      if ((ev && evt_rsp_done) || dead || intr) begin
        next_st.inst[i].mav = 1'b0;
      end
      if (ev && evt_rsp_ready) begin
        next_st.inst[i].mav = 1'b1;
      end
      // request service: new summary sets, serial poll clears
      mss = |(ser_stb(st.inst[i]) & st.inst[i].service_request_mask & SRE_USED_MASK);
      next_st.inst[i].mss_q = mss;
      if (hit && cmd_op == OP_POLL) begin
        next_st.inst[i].rqs = 1'b0;
      end
      if (mss && !st.inst[i].mss_q) begin
        next_st.inst[i].rqs = 1'b1;
      end
      next_st.parser_reset[i] = unterm || (ev && evt_cmd_error);
      next_st.discard[i] = dead || intr;
    end
    // answer to a query of the addressed instance
    if (cmd_inst < 3'(NUM_INST)) begin
      sel = st.inst[cmd_inst];
    end
    sel_stb = ser_stb(sel);
    if (cmd_valid) begin
      next_st.rsp_valid = 1'b1;
      case (cmd_op)
        OP_RD_LIM_EVT: next_st.rsp_data = (cmd_idx < 2'(NUM_OUT)) ? sel.lsr[cmd_idx] : 8'h00;
        OP_RD_LIM_MASK: next_st.rsp_data = (cmd_idx < 2'(NUM_OUT)) ? sel.lse[cmd_idx] : 8'h00;
        OP_RD_ESR: next_st.rsp_data = sel.standard_event_status;
        OP_RD_ESE: next_st.rsp_data = sel.standard_event_mask;
        OP_RD_EER: next_st.rsp_data = sel.execution_error_code;
        OP_RD_QER: next_st.rsp_data = sel.query_error_code;
        OP_RD_STB: next_st.rsp_data = sel_stb;
        OP_RD_SRE: next_st.rsp_data = sel.service_request_mask;
        OP_RD_PRE: next_st.rsp_data = sel.pre;
        OP_RD_IST: next_st.rsp_data = {7'h00, ser_ist(sel)};
        OP_POLL: next_st.rsp_data = {sel_stb[7], sel.rqs, sel_stb[5:0]};
        default: next_st.rsp_valid = 1'b0;
      endcase
    end
    // parallel poll configuration of the bus instance
    if (cmd_valid && cmd_inst == GPIB_INST && cmd_op == OP_PP_CONFIG) begin
      next_st.pp_cfg = 1'b1;
      next_st.pp_line = cmd_data[2:0];
      next_st.pp_sense = cmd_data[PP_SENSE_BIT];
    end
    if (cmd_valid && cmd_inst == GPIB_INST && cmd_op == OP_PP_UNCONFIG) begin
      next_st.pp_cfg = 1'b0;
    end
    next_st.srq = st.inst[GPIB_INST].rqs;
    next_st.ist = ser_ist(st.inst[GPIB_INST]);
    // pull the selected line low only when asserting, else leave it to pull-up
    next_st.dio_oe = 8'h00;
    if (st.pp_cfg && pp_active && (st.ist == st.pp_sense)) begin
      next_st.dio_oe[st.pp_line] = 1'b1;
    end
  end

  // state register; every instance powers up with the power-on event set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      for (int i = 0; i < NUM_INST; i++) begin
        st.inst[i].standard_event_status <= ESR_RESET;
        st.inst[i].standard_event_mask <= MASK_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign rsp_valid = st.rsp_valid;
  assign rsp_data = st.rsp_data;
  assign parser_reset = st.parser_reset;
  assign discard_rsp = st.discard;
  assign srq = st.srq;
  assign ist = st.ist;
  assign dio_out = st.dio_out;
  assign dio_oe = st.dio_oe;

  // observation helpers for instance 0
  assign stb0 = ser_stb(st.inst[0]);
  assign ist0 = ser_ist(st.inst[0]);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_query0(ser_op_e op);
    cmd_valid && cmd_inst == 3'h0 && cmd_op == op;
  endsequence

  sequence s_ev0;
    evt_inst == 3'h0;
  endsequence

  property p_esr_query;
    s_query0(OP_RD_ESR) |=> rsp_valid && rsp_data == $past(st.inst[0].standard_event_status)
      && (st.inst[0].standard_event_status & ~$past(esr_set[0])) == 8'h00;
  endproperty
  a_esr_query: assert property (p_esr_query)
    else $error("standard event query did not answer and clear");

  property p_ese_readback;
    s_query0(OP_WR_ESE) ##1 !cmd_valid ##1 s_query0(OP_RD_ESE) |=> rsp_data == $past(cmd_data, 3);
  endproperty
  a_ese_readback: assert property (p_ese_readback)
    else $error("event enable readback differs from last write");

  property p_eer_clear;
    s_query0(OP_RD_EER) ##0 !(evt_inst == 3'h0 && (evt_exec_wr || evt_access_denied))
      |=> st.inst[0].execution_error_code == EER_NONE && rsp_data == $past(st.inst[0].execution_error_code);
  endproperty
  a_eer_clear: assert property (p_eer_clear)
    else $error("execution error code not returned and cleared");

  property p_exec_sets_esr;
    s_ev0 ##0 evt_exec_wr && evt_exec_code != EER_NONE && !evt_access_denied
      |=> st.inst[0].execution_error_code == $past(evt_exec_code) && st.inst[0].standard_event_status[ESR_EXEC_ERR];
  endproperty
  a_exec_sets_esr: assert property (p_exec_sets_esr)
    else $error("nonzero execution code did not set event bit 4");

  property p_denied;
    s_ev0 ##0 evt_access_denied
      |=> st.inst[0].execution_error_code == EER_ACCESS_DENIED && st.inst[0].standard_event_status[ESR_EXEC_ERR];
  endproperty
  a_denied: assert property (p_denied)
    else $error("denied command did not load code 200");

  property p_unterminated;
    s_ev0 ##0 evt_talk_addressed && evt_formatter_idle && evt_queue_empty
      |=> st.inst[0].query_error_code == QER_UNTERMINATED && st.inst[0].standard_event_status[ESR_QUERY_ERR]
      && parser_reset[0];
  endproperty
  a_unterminated: assert property (p_unterminated)
    else $error("unterminated talk not reported");

  property p_deadlock;
    s_ev0 ##0 evt_queue_full && st.inst[0].mav
      && !(evt_talk_addressed && evt_formatter_idle && evt_queue_empty)
      |=> st.inst[0].query_error_code == QER_DEADLOCK && discard_rsp[0] && !st.inst[0].mav
      ##1 !discard_rsp[0] || $past(evt_inst == 3'h0 && evt_queue_full);
  endproperty
  a_deadlock: assert property (p_deadlock)
    else $error("deadlock not reported or discard not a pulse");

  property p_poll;
    s_query0(OP_POLL) |=> rsp_data[STB_MSS] == $past(st.inst[0].rqs)
      && st.inst[0].rqs == ($past(stb0[STB_MSS]) && !$past(st.inst[0].mss_q));
  endproperty
  a_poll: assert property (p_poll)
    else $error("serial poll did not return and clear request");

  property p_stb_query;
    s_query0(OP_RD_STB) |=> rsp_data == $past(stb0) && rsp_data[7] == 1'b0
      && rsp_data[3] == 1'b0;
  endproperty
  a_stb_query: assert property (p_stb_query)
    else $error("status byte query wrong");

  property p_verify;
    vfy_to[0] |=> st.inst[0].standard_event_status[ESR_VERIFY];
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify timeout did not set event bit 3");

  property p_limit_latch;
    lim_evt[0][6] |=> st.inst[0].lsr[0][6];
  endproperty
  a_limit_latch: assert property (p_limit_latch)
    else $error("fault trip event lost");

  property p_ist;
    ##1 ist == $past(ist0);
  endproperty
  a_ist: assert property (p_ist)
    else $error("parallel poll status does not follow byte and enable");

  property p_pp_drive;
    dio_oe != 8'h00 |-> $onehot0(dio_oe) && $past(st.pp_cfg) && $past(pp_active);
  endproperty
  a_pp_drive: assert property (p_pp_drive)
    else $error("poll line driven without configuration");
endmodule
`default_nettype wire

// File: core/ser_pkg.sv
/*
  constants, types and helper functions of the status and event reporting bank.
  assumes one system clock at 250 MHz and a command decoder outside that turns
  the text commands of each interface instance into single-cycle operations.
*/
// Operation
// - separate register set per interface instance
// - limit events latch trip and regulation bits
// - limit summary when event meets enable
// - limit events read-clear, limit enable read/write
// - standard event bit layout, bits 6,1 zero
// - command error sets bit, resets parser
// - verify timeout sets standard event bit
// - standard event read-clear, power-up value 128
// - event summary bit from events and enable
// - execution error holds last error code
// - execution error read-clear, zero at power-up
// - nonzero execution code sets event bit 4
// - master summary from status byte and enable
// - status query gives summary, poll clears request
// - message available until terminator sent
// - status byte limit bits, bits 7,3 zero
// - parallel poll status from byte and enable
// - poll line configured, released, passive pull-up
// - unterminated talk sets query error code 3
// - deadlock sets code 2, discards response
// - interrupted response sets code 1, discards
// - denied command sets bit 4, code 200
// - clear status clears error registers
`default_nettype none
package ser_pkg;
  // sizing
  localparam int NUM_INST = 6;
  localparam int NUM_OUT = 3;
  localparam int VFY_CNT_W = 31;
  localparam logic [2:0] GPIB_INST = 3'h0;
  // verify timing: 5 s at the system clock rate
  localparam longint unsigned CLK_HZ = 64'd250000000;
  localparam longint unsigned VERIFY_TIMEOUT_S = 64'd5;
  localparam int unsigned VERIFY_CYCLES_DEF = 32'(VERIFY_TIMEOUT_S * CLK_HZ);
  // standard event bit positions
  localparam int ESR_POWER_ON = 7;
  localparam int ESR_CMD_ERR = 5;
  localparam int ESR_EXEC_ERR = 4;
  localparam int ESR_VERIFY = 3;
  localparam int ESR_QUERY_ERR = 2;
  localparam int ESR_OP_DONE = 0;
  // status byte bit positions
  localparam int STB_MSS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  // reset values and masks
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] LIM_VALID_MASK = 8'h4F;
  localparam logic [7:0] SRE_USED_MASK = 8'hBF;
  // execution and query error codes
  localparam logic [7:0] EER_NONE = 8'h00;
  localparam logic [7:0] EER_RECALL_EMPTY = 8'h66;
  localparam logic [7:0] EER_INVALID = 8'h67;
  localparam logic [7:0] EER_ACCESS_DENIED = 8'hC8;
  localparam logic [7:0] QER_INTERRUPTED = 8'h01;
  localparam logic [7:0] QER_DEADLOCK = 8'h02;
  localparam logic [7:0] QER_UNTERMINATED = 8'h03;
  // parallel poll configure byte layout
  localparam int PP_SENSE_BIT = 3;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_RD_LIM_EVT = 5'h01,
    OP_WR_LIM_MASK = 5'h02,
    OP_RD_LIM_MASK = 5'h03,
    OP_RD_ESR = 5'h04,
    OP_WR_ESE = 5'h05,
    OP_RD_ESE = 5'h06,
    OP_RD_EER = 5'h07,
    OP_RD_QER = 5'h08,
    OP_RD_STB = 5'h09,
    OP_WR_SRE = 5'h0A,
    OP_RD_SRE = 5'h0B,
    OP_WR_PRE = 5'h0C,
    OP_RD_PRE = 5'h0D,
    OP_RD_IST = 5'h0E,
    OP_CLEAR = 5'h0F,
    OP_OPC = 5'h10,
    OP_POLL = 5'h11,
    OP_PP_CONFIG = 5'h12,
    OP_PP_UNCONFIG = 5'h13
  } ser_op_e;

  typedef struct packed {
    logic [NUM_OUT-1:0][7:0] lsr;
    logic [NUM_OUT-1:0][7:0] lse;
    logic [7:0] standard_event_status;
    logic [7:0] standard_event_mask;
    logic [7:0] execution_error_code;
    logic [7:0] query_error_code;
    logic [7:0] service_request_mask;
    logic [7:0] pre;
    logic mav;
    logic mss_q;
    logic rqs;
  } ser_inst_s;

  // status byte with master summary, combinational from the stored registers
  function automatic logic [7:0] ser_stb(input ser_inst_s r);
    logic [7:0] s;
    logic [NUM_OUT-1:0] lim;
    s = 8'h00;
    for (int o = 0; o < NUM_OUT; o++) begin
      lim[o] = |(r.lsr[o] & r.lse[o]);
    end
    s[NUM_OUT-1:0] = lim;
    s[STB_MAV] = r.mav;
    s[STB_ESB] = |(r.standard_event_status & r.standard_event_mask);
    s[STB_MSS] = |(s & r.service_request_mask & SRE_USED_MASK);
    return s;
  endfunction

  // parallel poll status message of one instance
  function automatic logic ser_ist(input ser_inst_s r);
    return |(ser_stb(r) & r.pre);
  endfunction
endpackage
`default_nettype wire

// File: core/ser_verify_timer.sv
/*
  verify timer of one interface instance: times a verified setting and pulses
  on expiry.
  assumes start and reached are single-cycle pulses from the settings logic.
*/
`default_nettype none
module ser_verify_timer #(
  parameter int unsigned CYCLES = ser_pkg::VERIFY_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // verify request and completion
  input wire logic start,
  input wire logic reached,
  // expiry pulse
  output logic timeout
);
  import ser_pkg::*;

  typedef struct packed {
    logic busy;
    logic [VFY_CNT_W-1:0] cnt;
    logic timeout;
  } ser_vfy_s;

  ser_vfy_s st;
  ser_vfy_s next_st;

  // counts while a verified setting waits for its target
  always_comb begin
    next_st = st;
    next_st.timeout = 1'b0;
    if (st.busy) begin
      next_st.cnt = st.cnt + 1'b1;
      if (st.cnt == VFY_CNT_W'(CYCLES - 1)) begin
        next_st.timeout = 1'b1;
        next_st.busy = 1'b0;
      end
    end
    if (reached) begin
      next_st.busy = 1'b0;
      next_st.timeout = 1'b0;
    end
    if (start) begin
      next_st.busy = 1'b1;
      next_st.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timeout = st.timeout;
endmodule
`default_nettype wire

// File: sim/ser_bus_model.sv
/*
  far-side model of the bus poll lines: pull-ups resolve the data lines from
  the bank's open-drain enables; a poll window opens on the bench's request.
  assumes the bank only ever pulls lines low through its enables.
*/
`default_nettype none
module ser_bus_model (
  // clock
  input wire logic clk,
  // poll request and bank drive enables
  input wire logic poll_req,
  input wire logic [7:0] dio_oe,
  input wire logic [7:0] dio_out,
  // poll window and resolved lines
  output logic pp_active,
  output logic [7:0] dio_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle lines float high, a pulled line reads its driven data
  assign dio_lines = ~dio_oe | dio_out;
  // poll window opens one edge after the request
  always_ff @(posedge clk) begin
    pp_active <= poll_req;
  end
endmodule
`default_nettype wire

// File: sim/ser_status_bank_bench.sv
/*
  self-checking bench of the status bank: register ops, event pulses, polls.
  assumes the one-cycle op strobe and registered answer of the bank.
*/
`default_nettype none
module ser_status_bank_bench
  import ser_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // stimulus and observed signals
  logic clk = 0, rst = 1, cmd_valid = 0, poll_req = 0;
  logic [2:0] cmd_inst = 0, evt_i = 0;
  ser_op_e cmd_op = OP_NONE;
  logic [1:0] cmd_idx = 0;
  logic [7:0] cmd_data = 0, code = 0;
  logic [12:0] ev = 0;
  logic [NUM_OUT-1:0][7:0] lim = '0;
  logic rsp_valid, srq, ist, pp_active;
  logic [7:0] rsp_data, dio_out, dio_oe, dio_lines;
  logic [NUM_INST-1:0] parser_reset, discard_rsp;
  int errors = 0, total_checks = 0, cycles = 0, prc = 0, drc = 0;
  // event bits: 0 cmd err,1 exec wr,2 denied,3 vstart,4 vreach,5 talk,6 idle,
  // 7 empty,8 full,9 term,10 multi end,11 rsp ready,12 rsp done
  ser_status_bank #(.VERIFY_CYCLES(20)) DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_inst(cmd_inst), .cmd_op(cmd_op), .cmd_idx(cmd_idx), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .lim_evt(lim), .evt_inst(evt_i),
    .evt_cmd_error(ev[0]), .evt_exec_wr(ev[1]), .evt_exec_code(code),
    .evt_access_denied(ev[2]), .evt_verify_start(ev[3]), .evt_verify_reached(ev[4]),
    .evt_talk_addressed(ev[5]), .evt_formatter_idle(ev[6]), .evt_queue_empty(ev[7]),
    .evt_queue_full(ev[8]), .evt_terminator(ev[9]), .evt_multi_end(ev[10]),
    .evt_rsp_ready(ev[11]), .evt_rsp_done(ev[12]), .parser_reset(parser_reset),
    .discard_rsp(discard_rsp), .srq(srq), .ist(ist), .pp_active(pp_active),
    .dio_out(dio_out), .dio_oe(dio_oe));
  ser_bus_model bus (.clk(clk), .poll_req(poll_req), .dio_oe(dio_oe), .dio_out(dio_out),
    .pp_active(pp_active), .dio_lines(dio_lines));
  // clock
  always #2 clk = ~clk;
  // count control pulses where they are settled and cut a hang short
  always @(negedge clk) begin
    cycles++;
    if (parser_reset[0] === 1'b1) prc++;
    if (discard_rsp[0] === 1'b1) drc++;
    if (cycles == 3000) begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one operation strobe, answer sampled after the taking edge
  task automatic op(input logic [2:0] i, input ser_op_e o, input logic [1:0] x,
                    input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_inst <= i;
    cmd_op <= o;
    cmd_idx <= x;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] i, input ser_op_e o, input logic [1:0] x,
                    input logic [7:0] e);
    op(i, o, x, 8'h00);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data, e);
  endtask
  // event pulse for one instance, then one edge so its registered effects settle
  task automatic pulse(input logic [12:0] m, input logic [7:0] c,
                       input logic [2:0] i = 3'h0);
    @(posedge clk);
    ev <= m;
    code <= c;
    evt_i <= i;
    @(posedge clk);
    ev <= '0;
    evt_i <= 3'h0;
    @(posedge clk);
    #1;
  endtask
  // parallel poll window, lines checked inside it and after it closes
  task automatic poll(input logic [7:0] e);
    @(posedge clk);
    poll_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(dio_lines, e);
    @(posedge clk);
    poll_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(dio_lines, 8'hFF);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(0, OP_RD_ESR, 0, 8'h80);
    rd(0, OP_RD_ESR, 0, 8'h00);
    rd(0, OP_RD_ESE, 0, 8'h00);
    rd(0, OP_RD_EER, 0, 8'h00);
    rd(0, OP_RD_STB, 0, 8'h00);
    op(0, OP_WR_ESE, 0, 8'hFF);
    chk({7'h00, rsp_valid}, 8'h00);
    rd(0, OP_RD_ESE, 0, 8'hFF);
    pulse(13'h0001, 8'h00);
    chk(8'(prc), 8'h01);
    rd(0, OP_RD_STB, 0, 8'h20);
    rd(0, OP_RD_ESR, 0, 8'h20);
    op(0, OP_WR_ESE, 0, 8'h00);
    $display("test standard events done");
    pulse(13'h0002, 8'h66);
    rd(0, OP_RD_EER, 0, 8'h66);
    rd(0, OP_RD_EER, 0, 8'h00);
    rd(0, OP_RD_ESR, 0, 8'h10);
    pulse(13'h0006, 8'h67);
    rd(0, OP_RD_EER, 0, 8'hC8);
    op(0, OP_OPC, 0, 8'h00);
    rd(0, OP_RD_ESR, 0, 8'h11);
    pulse(13'h0002, 8'h67);
    op(0, OP_CLEAR, 0, 8'h00);
    rd(0, OP_RD_EER, 0, 8'h00);
    rd(0, OP_RD_ESR, 0, 8'h00);
    $display("test execution errors done");
    pulse(13'h00E0, 8'h00);
    rd(0, OP_RD_QER, 0, 8'h03);
    chk(8'(prc), 8'h02);
    pulse(13'h0800, 8'h00);
    rd(0, OP_RD_STB, 0, 8'h10);
    pulse(13'h0100, 8'h00);
    rd(0, OP_RD_QER, 0, 8'h02);
    chk(8'(drc), 8'h01);
    rd(0, OP_RD_STB, 0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      pulse(13'h0800, 8'h00);
      pulse(k == 0 ? 13'h0200 : 13'h0400, 8'h00);
      rd(0, OP_RD_QER, 0, 8'h01);
    end
    rd(0, OP_RD_ESR, 0, 8'h04);
    pulse(13'h0800, 8'h00);
    pulse(13'h1000, 8'h00);
    rd(0, OP_RD_STB, 0, 8'h00);
    $display("test query errors done");
    pulse(13'h0008, 8'h00);
    repeat (25) @(posedge clk);
    rd(0, OP_RD_ESR, 0, 8'h08);
    pulse(13'h0008, 8'h00);
    pulse(13'h0010, 8'h00);
    repeat (25) @(posedge clk);
    rd(0, OP_RD_ESR, 0, 8'h00);
    $display("test verify timer done");
    op(0, OP_WR_LIM_MASK, 1, 8'h04);
    rd(0, OP_RD_LIM_MASK, 1, 8'h04);
    @(posedge clk);
    lim[0] <= 8'hF0;
    lim[1] <= 8'h04;
    @(posedge clk);
    lim <= '0;
    rd(0, OP_RD_STB, 0, 8'h02);
    op(0, OP_WR_PRE, 0, 8'h02);
    rd(0, OP_RD_IST, 0, 8'h01);
    chk({7'h00, ist}, 8'h01);
    op(0, OP_PP_CONFIG, 0, 8'h0B);
    poll(8'hF7);
    op(0, OP_PP_UNCONFIG, 0, 8'h00);
    poll(8'hFF);
    op(0, OP_WR_SRE, 0, 8'h02);
    rd(0, OP_RD_STB, 0, 8'h42);
    chk({7'h00, srq}, 8'h01);
    rd(0, OP_RD_SRE, 0, 8'h02);
    rd(0, OP_RD_PRE, 0, 8'h02);
    rd(0, OP_POLL, 0, 8'h42);
    rd(0, OP_POLL, 0, 8'h02);
    chk({7'h00, srq}, 8'h00);
    rd(0, OP_RD_STB, 0, 8'h42);
    rd(0, OP_RD_LIM_EVT, 1, 8'h04);
    rd(0, OP_RD_LIM_EVT, 1, 8'h00);
    rd(0, OP_RD_LIM_EVT, 0, 8'h40);
    rd(0, OP_RD_STB, 0, 8'h00);
    rd(1, OP_RD_LIM_EVT, 1, 8'h04);
    rd(6, OP_RD_ESR, 0, 8'h00);
    pulse(13'h0001, 8'h00, 3'h1);
    rd(1, OP_RD_ESR, 0, 8'hA0);
    rd(0, OP_RD_ESR, 0, 8'h00);
    chk(8'(prc), 8'h02);
    $display("test limits and polls done");
    close_out();
  end
endmodule
`default_nettype wire
